// ### logic/stls_defines.vh
// register offsets, field layouts, reset values and timing counts of the torque limit selector
`ifndef STLS_DEFINES_VH
`define STLS_DEFINES_VH
// register word indices (byte address = 4 * index)
`define STLS_IDX_UV_CFG 8'h45
`define STLS_IDX_UV_PCT 8'h46
`define STLS_IDX_UV_REL 8'h47
`define STLS_IDX_METHOD 8'h50
`define STLS_IDX_LIM1 8'h51
`define STLS_IDX_LIM2 8'h52
`define STLS_IDX_ASCALE 8'h53
`define STLS_IDX_ICMD 8'h54
`define STLS_IDX_MOTMAX 8'h55
`define STLS_IDX_CTRL 8'h56
`define STLS_IDX_STAT 8'h57
`define STLS_IDX_IRQ_ST 8'h58
`define STLS_IDX_IRQ_MSK 8'h59
`define STLS_IDX_FWD_LIM 8'h5A
`define STLS_IDX_REV_LIM 8'h5B
// reset values
`define STLS_RST_UV_CFG 16'h0000
`define STLS_RST_UV_PCT 16'h0032
`define STLS_RST_UV_REL 16'h0064
`define STLS_RST_METHOD 16'h0001
`define STLS_RST_LIM 16'h0BB8
`define STLS_RST_ASCALE 16'h0100
`define STLS_RST_MOTMAX 16'h0BB8
// method and under-voltage mode codes
`define STLS_M_ANALOG 3'h0
`define STLS_M_ONE 3'h1
`define STLS_M_SPLIT 3'h2
`define STLS_M_SWITCH 3'h3
`define STLS_M_INTERNAL 3'h4
`define STLS_UV_OFF 2'h0
`define STLS_UV_DETECT 2'h1
`define STLS_UV_LIMIT 2'h2
// field positions
`define STLS_CTRL_TORQUE_MODE 0
`define STLS_IRQ_ACTIVE 0
`define STLS_IRQ_UV 1
`define STLS_IRQ_RELEASED 2
// timing: one millisecond tick at the clock rate
`define STLS_CLK_HZ 100000000
`define STLS_TICK_US 1000
`define STLS_PCT_FULL 16'h0064
`endif

// ### logic/stls_sync.v
// two flip-flop synchroniser for asynchronous levels
`default_nettype none
module stls_sync #(
  parameter W = 2
) (
  input wire clk_i, // clock
  input wire rst_i, // synchronous reset
  input wire [W-1:0] d_i, // asynchronous level
  output wire [W-1:0] q_o // synchronised level
);
  reg [W-1:0] meta; // first stage, read only by second
  reg [W-1:0] sync; // second stage
  // shift the level through two stages
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      sync <= {W{1'b0}};
    end else begin
      meta <= d_i;
      sync <= meta;
    end
  end
  assign q_o = sync;
endmodule // stls_sync
`default_nettype wire

// ### logic/stls_tick.v
// divider that makes a one-cycle enable pulse every period
`default_nettype none
module stls_tick #(
  parameter DIV = 100000
) (
  input wire clk_i, // clock
  input wire rst_i, // synchronous reset
  output reg tick_o // one-cycle enable
);
  reg [31:0] cnt; // cycle counter
  // count up to one period, pulse, restart
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (cnt == DIV - 1) begin
      cnt <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick_o <= 1'b0;
    end
  end
endmodule // stls_tick
`default_nettype wire

// ### logic/stls_top.v
// torque limit selector with under-voltage limit and release ramp
// Summary of operation
// R1: method 0 uses analog input, not torque mode
// R2: method 1 applies limit one both ways
// R3: method 2 forward limit one, reverse two
// R4: method 3 switch input picks one or two
// R5: method 4 uses internal torque command value, torque mode only
// R6: analog magnitude only, same both directions
// R7: clamp every limit to motor maximum
// R8: active output high while torque at limit
// R9: uv mode off, detect, or detect and limit
// R10: under-voltage limit is percent, default 50
// R11: release over programmed time, default 100 ms
// R12: ramp linearly back to normal limit
`include "stls_defines.vh"
`default_nettype none
module stls_top #(
  parameter TICK_DIV = `STLS_CLK_HZ / 1000000 * `STLS_TICK_US // cycles per millisecond
) (
  input wire REF_CLK_I, // clock, 100 MHz
  input wire SRST_I, // synchronous reset, active high
  input wire [7:0] AVS_ADDRESS_I, // word address
  input wire AVS_READ_I, // read strobe
  input wire AVS_WRITE_I, // write strobe
  input wire [3:0] AVS_BYTEENABLE_I, // byte enables
  input wire [31:0] AVS_WRITEDATA_I, // write data
  output reg [31:0] AVS_READDATA_O, // read data
  output wire AVS_WAITREQUEST_O, // wait request
  input wire TORQUE_LIMIT_SWITCH_INPUT_I, // limit switching pin, high = on
  input wire UV_WARNING_I, // main-circuit under-voltage pin
  input wire signed [15:0] ANALOG_TORQUE_I, // analog torque sample, same clock
  input wire signed [15:0] TORQUE_DEMAND_I, // torque demand before limiting
  output reg signed [15:0] TORQUE_OUT_O, // limited torque
  output reg [15:0] FWD_LIMIT_O, // effective forward limit
  output reg [15:0] REV_LIMIT_O, // effective reverse limit
  output reg TORQUE_LIMIT_ACTIVE_OUTPUT_O, // torque held at limit
  output reg UV_WARNING_O, // detected under-voltage warning
  output wire IRQ_O // level interrupt
);
  // registers
  reg [1:0] uv_cfg; // undervoltage_function_config
  reg [15:0] uv_pct; // undervoltage_torque_limit_pct
  reg [15:0] uv_rel; // undervoltage_release_time_ms
  reg [2:0] method; // torque_limit_method_select
  reg [15:0] lim1; // torque_limit_one
  reg [15:0] lim2; // torque_limit_two
  reg [15:0] ascale; // analog_limit_scaling, 8.8 fixed
  reg [15:0] icmd; // internal_torque_command
  reg [15:0] motmax; // motor maximum torque
  reg torque_mode; // drive runs torque control
  reg [2:0] irq_st; // sticky events
  reg [2:0] irq_msk; // interrupt mask
  localparam [15:0] RST_UV_CFG = `STLS_RST_UV_CFG; // uv mode at reset, cut to field width below
  localparam [15:0] RST_METHOD = `STLS_RST_METHOD; // method at reset, cut to field width below
  // state
  localparam ST_NORM = 3'b001; // no restriction
  localparam ST_UV = 3'b010; // warning held
  localparam ST_REL = 3'b100; // release ramp
  reg [2:0] state; // under-voltage state
  reg [15:0] rel_cnt; // elapsed ms of release
  wire [1:0] pins; // synchronised pins
  wire sw_on; // switch input synchronised
  wire uv_pin; // warning synchronised
  wire tick; // millisecond enable
  reg active_d; // previous active level
  reg uv_d; // previous warning level
  wire wr = AVS_WRITE_I; // write strobe
  wire [31:0] wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                       {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

  // merge write data into an old 16-bit value by byte enables
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [31:0] m;
    begin
      merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
    end
  endfunction

  // smaller of two limits
  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // magnitude of a signed value
  function [15:0] abs16;
    input signed [15:0] v;
    begin
      abs16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  stls_sync #(.W(2)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .d_i({UV_WARNING_I, TORQUE_LIMIT_SWITCH_INPUT_I}),
    .q_o(pins)
  );
  assign sw_on = pins[0];
  assign uv_pin = pins[1];

  stls_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .tick_o(tick)
  );

  // reads take one wait state so the registered read data stands
  // at the edge where waitrequest is seen low; writes never wait
  reg rd_ack; // read data loaded, answer now
  wire rd_take = AVS_READ_I & ~rd_ack; // first cycle of a read
  assign AVS_WAITREQUEST_O = rd_take;

  // acknowledge a read one cycle after it is presented
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= rd_take;
    end
  end

  // uv detection only when enabled
  wire uv_det = (uv_cfg != `STLS_UV_OFF) & uv_pin; // see R9
  wire uv_lim_en = (uv_cfg == `STLS_UV_LIMIT); // see R9

  // base limits by method
  reg [15:0] base_fwd; // forward limit before uv and clamp
  reg [15:0] base_rev; // reverse limit before uv and clamp
  reg [31:0] aprod; // analog magnitude times scale
  reg limit_en; // method applies in this mode
  always @* begin
    aprod = abs16(ANALOG_TORQUE_I) * ascale; // see R6
    base_fwd = lim1;
    base_rev = lim1;
    limit_en = 1'b1;
    case (method)
      `STLS_M_ANALOG: begin
        // same magnitude both ways
        base_fwd = (aprod[31:24] != 8'h00) ? 16'hFFFF : aprod[23:8]; // see R6
        base_rev = base_fwd; // see R6
        limit_en = ~torque_mode; // see R1
      end
      `STLS_M_ONE: begin
        base_fwd = lim1; // see R2
        base_rev = lim1; // see R2
      end
      `STLS_M_SPLIT: begin
        base_fwd = lim1; // see R3
        base_rev = lim2; // see R3
      end
      `STLS_M_SWITCH: begin
        base_fwd = sw_on ? lim2 : lim1; // see R4
        base_rev = base_fwd; // see R4
      end
      `STLS_M_INTERNAL: begin
        base_fwd = icmd; // see R5
        base_rev = icmd; // see R5
        limit_en = torque_mode; // see R5
      end
      default: begin
        // unknown code: plain limit one
        base_fwd = lim1;
        base_rev = lim1;
      end
    endcase
    if (!limit_en) begin
      base_fwd = 16'hFFFF;
      base_rev = 16'hFFFF;
    end
  end

  // under-voltage limit and linear release ramp
  reg [31:0] uv_prod; // motor max times percent
  reg [15:0] uv_abs; // under-voltage limit in torque units
  reg [15:0] norm_fwd; // clamped forward
  reg [15:0] norm_rev; // clamped reverse
  reg [15:0] ramp_fwd; // ramped forward
  reg [15:0] ramp_rev; // ramped reverse
  reg [15:0] pct_eff; // percent clipped to 100
  reg [31:0] rtmp; // ramp arithmetic
  reg [31:0] uv_div; // under-voltage limit before narrowing
  always @* begin
    pct_eff = (uv_pct > `STLS_PCT_FULL) ? `STLS_PCT_FULL : uv_pct; // see R10
    uv_prod = motmax * pct_eff; // see R10
    // divide the full product, never a truncated one
    uv_div = uv_prod / {16'h0000, `STLS_PCT_FULL}; // see R10
    uv_abs = (uv_div > 32'h0000FFFF) ? 16'hFFFF : uv_div[15:0]; // see R10
    norm_fwd = min16(base_fwd, motmax); // see R7
    norm_rev = min16(base_rev, motmax); // see R7
    ramp_fwd = norm_fwd;
    ramp_rev = norm_rev;
    rtmp = 32'h00000000;
    case (state)
      ST_UV: begin
        ramp_fwd = min16(norm_fwd, uv_abs); // see R10
        ramp_rev = min16(norm_rev, uv_abs); // see R10
      end
      ST_REL: begin
        // uv limit plus elapsed share of the gap
        if (norm_fwd > uv_abs && uv_rel != 16'h0000) begin
          rtmp = (norm_fwd - uv_abs) * rel_cnt / uv_rel; // see R12
          ramp_fwd = uv_abs + rtmp[15:0]; // see R12
        end
        if (norm_rev > uv_abs && uv_rel != 16'h0000) begin
          rtmp = (norm_rev - uv_abs) * rel_cnt / uv_rel; // see R12
          ramp_rev = uv_abs + rtmp[15:0]; // see R12
        end
      end
      ST_NORM: begin
        ramp_fwd = norm_fwd;
        ramp_rev = norm_rev;
      end
      default: begin
        ramp_fwd = norm_fwd;
        ramp_rev = norm_rev;
      end
    endcase
  end

  // torque after limiting and active flag
  wire [15:0] dem_mag = abs16(TORQUE_DEMAND_I); // demand magnitude
  wire dem_neg = TORQUE_DEMAND_I[15]; // reverse direction
  wire [15:0] cur_lim = dem_neg ? ramp_rev : ramp_fwd; // limit of this direction
  wire at_limit = (dem_mag >= cur_lim); // see R8
  wire [15:0] lim_mag = at_limit ? cur_lim : dem_mag; // clipped magnitude

  // state machine for under-voltage restriction
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state <= ST_NORM;
      rel_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_NORM: begin
          if (uv_det && uv_lim_en) begin
            state <= ST_UV; // see R10
          end
        end
        ST_UV: begin
          if (!uv_lim_en) begin
            state <= ST_NORM;
          end else if (!uv_det) begin
            rel_cnt <= 16'h0000;
            state <= (uv_rel == 16'h0000) ? ST_NORM : ST_REL; // see R11
          end
        end
        ST_REL: begin
          if (uv_det && uv_lim_en) begin
            state <= ST_UV; // warning returns
          end else if (!uv_lim_en || rel_cnt >= uv_rel) begin
            state <= ST_NORM; // see R11
          end else if (tick) begin
            rel_cnt <= rel_cnt + 16'h0001; // see R11
          end
        end
        default: begin
          state <= ST_NORM;
        end
      endcase
    end
  end

  // output registers
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      TORQUE_OUT_O <= 16'sh0000;
      FWD_LIMIT_O <= 16'h0000;
      REV_LIMIT_O <= 16'h0000;
      TORQUE_LIMIT_ACTIVE_OUTPUT_O <= 1'b0;
      UV_WARNING_O <= 1'b0;
      active_d <= 1'b0;
      uv_d <= 1'b0;
    end else begin
      TORQUE_OUT_O <= dem_neg ? (~lim_mag + 16'h0001) : lim_mag;
      FWD_LIMIT_O <= ramp_fwd;
      REV_LIMIT_O <= ramp_rev;
      TORQUE_LIMIT_ACTIVE_OUTPUT_O <= at_limit; // see R8
      UV_WARNING_O <= uv_det; // see R9
      active_d <= at_limit;
      uv_d <= uv_det;
    end
  end

  // events: active rise, warning rise, warning fall
  wire [2:0] ev = {uv_d & ~uv_det, uv_det & ~uv_d, at_limit & ~active_d};
  assign IRQ_O = |(irq_st & irq_msk);

  // register writes; hardware set wins over write-one clear
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      uv_cfg <= RST_UV_CFG[1:0];
      uv_pct <= `STLS_RST_UV_PCT;
      uv_rel <= `STLS_RST_UV_REL;
      method <= RST_METHOD[2:0];
      lim1 <= `STLS_RST_LIM;
      lim2 <= `STLS_RST_LIM;
      ascale <= `STLS_RST_ASCALE;
      icmd <= `STLS_RST_LIM;
      motmax <= `STLS_RST_MOTMAX;
      torque_mode <= 1'b0;
      irq_st <= 3'h0;
      irq_msk <= 3'h0;
    end else begin
      if (wr) begin
        case (AVS_ADDRESS_I)
          `STLS_IDX_UV_CFG: uv_cfg <= merge16({14'h0000, uv_cfg}, AVS_WRITEDATA_I, wmask) > 16'h0002 ?
                                      uv_cfg : AVS_WRITEDATA_I[1:0]; // see R9
          `STLS_IDX_UV_PCT: uv_pct <= merge16(uv_pct, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_UV_REL: uv_rel <= merge16(uv_rel, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_METHOD: method <= AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[2:0] : method;
          `STLS_IDX_LIM1: lim1 <= merge16(lim1, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_LIM2: lim2 <= merge16(lim2, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_ASCALE: ascale <= merge16(ascale, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_ICMD: icmd <= merge16(icmd, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_MOTMAX: motmax <= merge16(motmax, AVS_WRITEDATA_I, wmask);
          `STLS_IDX_CTRL: torque_mode <= AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[`STLS_CTRL_TORQUE_MODE] : torque_mode;
          `STLS_IDX_IRQ_MSK: irq_msk <= AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[2:0] : irq_msk;
          default: begin
            // other words hold nothing writable here; the irq status word is cleared below
          end
        endcase
      end
      if (wr && AVS_ADDRESS_I == `STLS_IDX_IRQ_ST && AVS_BYTEENABLE_I[0]) begin
        irq_st <= (irq_st & ~AVS_WRITEDATA_I[2:0]) | ev;
      end else begin
        irq_st <= irq_st | ev;
      end
    end
  end

  // read mux, registered read data, unmapped reads zero
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else if (rd_take) begin
      case (AVS_ADDRESS_I)
        `STLS_IDX_UV_CFG: AVS_READDATA_O <= {30'h00000000, uv_cfg};
        `STLS_IDX_UV_PCT: AVS_READDATA_O <= {16'h0000, uv_pct};
        `STLS_IDX_UV_REL: AVS_READDATA_O <= {16'h0000, uv_rel};
        `STLS_IDX_METHOD: AVS_READDATA_O <= {29'h00000000, method};
        `STLS_IDX_LIM1: AVS_READDATA_O <= {16'h0000, lim1};
        `STLS_IDX_LIM2: AVS_READDATA_O <= {16'h0000, lim2};
        `STLS_IDX_ASCALE: AVS_READDATA_O <= {16'h0000, ascale};
        `STLS_IDX_ICMD: AVS_READDATA_O <= {16'h0000, icmd};
        `STLS_IDX_MOTMAX: AVS_READDATA_O <= {16'h0000, motmax};
        `STLS_IDX_CTRL: AVS_READDATA_O <= {31'h00000000, torque_mode};
        `STLS_IDX_STAT: AVS_READDATA_O <= {26'h0000000, state, uv_det, sw_on, at_limit};
        `STLS_IDX_IRQ_ST: AVS_READDATA_O <= {29'h00000000, irq_st};
        `STLS_IDX_IRQ_MSK: AVS_READDATA_O <= {29'h00000000, irq_msk};
        `STLS_IDX_FWD_LIM: AVS_READDATA_O <= {16'h0000, ramp_fwd};
        `STLS_IDX_REV_LIM: AVS_READDATA_O <= {16'h0000, ramp_rev};
        default: AVS_READDATA_O <= 32'h00000000;
      endcase
    end
  end
endmodule // stls_top
`default_nettype wire

// ### dv/stls_chk_sva.sv
// port assertions for the torque limit selector
`default_nettype none
module stls_chk (
  input wire logic REF_CLK_I, // clock
  input wire logic SRST_I, // sync reset
  input wire logic AVS_READ_I, // read strobe
  input wire logic [31:0] AVS_READDATA_O, // read data
  input wire logic AVS_WAITREQUEST_O, // wait request
  input wire logic UV_WARNING_I, // uv pin
  input wire logic signed [15:0] TORQUE_OUT_O, // limited torque
  input wire logic [15:0] FWD_LIMIT_O, // forward limit
  input wire logic [15:0] REV_LIMIT_O, // reverse limit
  input wire logic TORQUE_LIMIT_ACTIVE_OUTPUT_O, // held at limit
  input wire logic UV_WARNING_O, // uv warning
  input wire logic IRQ_O // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  // pin seen through the two-stage sync plus output flop
  sequence s_pin_hi;
    $past(UV_WARNING_I, 2) || $past(UV_WARNING_I, 3);
  endsequence
  sequence s_pin_lo;
    !$past(UV_WARNING_I, 2) || !$past(UV_WARNING_I, 3);
  endsequence
  property p_rst;
    disable iff (1'b0) SRST_I |=> (TORQUE_OUT_O == 16'h0000) && !IRQ_O && !UV_WARNING_O;
  endproperty
  // a held read waits exactly one cycle
  property p_wait;
    AVS_READ_I && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
  endproperty
  // without a read nothing waits
  property p_nowait;
    !AVS_READ_I |-> !AVS_WAITREQUEST_O;
  endproperty
  property p_uv_rise;
    $rose(UV_WARNING_O) |-> s_pin_hi;
  endproperty
  property p_uv_fall;
    $fell(UV_WARNING_O) |-> s_pin_lo;
  endproperty
  // at limit the output sits exactly on the limit of its direction
  property p_act_fwd;
    TORQUE_LIMIT_ACTIVE_OUTPUT_O && (TORQUE_OUT_O > 0) && $stable(FWD_LIMIT_O)
      |-> $unsigned(TORQUE_OUT_O) == FWD_LIMIT_O;
  endproperty
  property p_act_rev;
    TORQUE_LIMIT_ACTIVE_OUTPUT_O && (TORQUE_OUT_O < 0) && $stable(REV_LIMIT_O)
      |-> (16'h0000 - $unsigned(TORQUE_OUT_O)) == REV_LIMIT_O;
  endproperty
  // below the limit a forward output stays under the forward limit
  property p_free;
    !TORQUE_LIMIT_ACTIVE_OUTPUT_O && (TORQUE_OUT_O > 0) && $stable(FWD_LIMIT_O)
      |-> $unsigned(TORQUE_OUT_O) < FWD_LIMIT_O;
  endproperty
  property p_rdata;
    !$past(AVS_READ_I) |-> $stable(AVS_READDATA_O);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_wait: assert property (p_wait) else $error("read held in wait more than one cycle");
  a_nowait: assert property (p_nowait) else $error("wait request raised without a read");
  a_uv_rise: assert property (p_uv_rise) else $error("uv warning rose without pin");
  a_uv_fall: assert property (p_uv_fall) else $error("uv warning fell with pin high");
  a_act_fwd: assert property (p_act_fwd) else $error("active but not at fwd limit");
  a_act_rev: assert property (p_act_rev) else $error("active but not at rev limit");
  a_free: assert property (p_free) else $error("inactive yet at limit");
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule // stls_chk
bind stls_top stls_chk u_chk (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .AVS_READ_I(AVS_READ_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .UV_WARNING_I(UV_WARNING_I),
  .TORQUE_OUT_O(TORQUE_OUT_O), .FWD_LIMIT_O(FWD_LIMIT_O), .REV_LIMIT_O(REV_LIMIT_O),
  .TORQUE_LIMIT_ACTIVE_OUTPUT_O(TORQUE_LIMIT_ACTIVE_OUTPUT_O), .UV_WARNING_O(UV_WARNING_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### dv/stls_motor.sv
// motor and host side model: pins and demand toward the selector
`default_nettype none
module stls_motor (
  input wire logic clk_i, // clock
  output logic sw_o, // limit switching pin, high = on
  output logic uv_o, // under-voltage warning pin
  output logic signed [15:0] analog_o, // analog torque sample
  output logic signed [15:0] demand_o // torque demand
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet motor at power-up
  initial begin
    sw_o = 1'b0;
    uv_o = 1'b0;
    analog_o = 16'sh0000;
    demand_o = 16'sh0000;
  end
  // new pin levels land just after an edge
  task automatic drive(input logic s, input logic u, input logic signed [15:0] a, input logic signed [15:0] d);
    sw_o <= s;
    uv_o <= u;
    analog_o <= a;
    demand_o <= d;
  endtask
endmodule // stls_motor
`default_nettype wire

// ### dv/servo_torque_limit_selector_test.sv
// self-checking bench for the torque limit selector
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module servo_torque_limit_selector_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TDIV = 10; // short millisecond tick
  int checks = 0; // comparisons made
  int n_mismatch = 0; // mismatches seen
  int cyc = 0; // timeout counter
  logic clk = 1'b0; // 100 MHz clock
  logic rst = 1'b1; // sync reset
  logic [7:0] adr = 8'h00; // bus address
  logic rd_s = 1'b0; // read strobe
  logic wr_s = 1'b0; // write strobe
  logic [31:0] wd = 32'h00000000; // write data
  logic [31:0] v; // read result
  wire [31:0] rdata; // read data
  wire wreq; // wait request
  wire sw; // switch pin
  wire uv; // uv pin
  wire signed [15:0] ana; // analog sample
  wire signed [15:0] dem; // demand
  wire signed [15:0] tout; // limited torque
  wire [15:0] fwd; // forward limit
  wire [15:0] rev; // reverse limit
  wire act; // at limit
  wire uvo; // uv warning out
  wire irq; // interrupt
  always #5 clk = ~clk;
  stls_motor mot (.clk_i(clk), .sw_o(sw), .uv_o(uv), .analog_o(ana), .demand_o(dem));
  stls_top #(.TICK_DIV(TDIV)) dut (.REF_CLK_I(clk), .SRST_I(rst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .TORQUE_LIMIT_SWITCH_INPUT_I(sw),
    .UV_WARNING_I(uv), .ANALOG_TORQUE_I(ana), .TORQUE_DEMAND_I(dem), .TORQUE_OUT_O(tout),
    .FWD_LIMIT_O(fwd), .REV_LIMIT_O(rev), .TORQUE_LIMIT_ACTIVE_OUTPUT_O(act),
    .UV_WARNING_O(uvo), .IRQ_O(irq));
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  // bus write, held until wait request is seen low
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr_s <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  // bus read, data taken at the edge that sees wait request low
  task automatic rd(input logic [7:0] a);
    adr <= a;
    rd_s <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdata;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask
  // drive pins then let the sync and output flops settle
  task automatic put(input logic s, input logic u, input logic signed [15:0] a, input logic signed [15:0] d);
    mot.drive(s, u, a, d);
    repeat (6) @(posedge clk);
  endtask
  task automatic t_regs;
    rd(8'h45);
    `CHK(v, 32'h00000000);
    rd(8'h46);
    `CHK(v, 32'h00000032);
    rd(8'h47);
    `CHK(v, 32'h00000064);
    rd(8'h10);
    `CHK(v, 32'h00000000);
  endtask
  task automatic t_one;
    wr(8'h51, 32'h000003E8);
    put(1'b0, 1'b0, 16'sh0000, 16'sd2000);
    `CHK(tout, 16'sh03E8);
    `CHK(act, 1'b1);
    put(1'b0, 1'b0, 16'sh0000, -16'sd2000);
    `CHK(tout, 16'shFC18);
    put(1'b0, 1'b0, 16'sh0000, 16'sd500);
    `CHK(tout, 16'sh01F4);
    `CHK(act, 1'b0);
  endtask
  task automatic t_split;
    wr(8'h52, 32'h000001F4);
    wr(8'h50, 32'h00000002);
    put(1'b0, 1'b0, 16'sh0000, -16'sd2000);
    `CHK(fwd, 16'h03E8);
    `CHK(rev, 16'h01F4);
    `CHK(tout, 16'shFE0C);
  endtask
  task automatic t_switch;
    wr(8'h50, 32'h00000003);
    put(1'b0, 1'b0, 16'sh0000, 16'sh0000);
    `CHK(fwd, 16'h03E8);
    `CHK(rev, 16'h03E8);
    put(1'b1, 1'b0, 16'sh0000, 16'sh0000);
    `CHK(fwd, 16'h01F4);
    `CHK(rev, 16'h01F4);
  endtask
  task automatic t_analog;
    wr(8'h50, 32'h00000000);
    put(1'b0, 1'b0, -16'sd800, 16'sh0000);
    `CHK(fwd, 16'h0320);
    `CHK(rev, 16'h0320);
    wr(8'h56, 32'h00000001);
    put(1'b0, 1'b0, -16'sd800, 16'sh0000);
    `CHK(fwd, 16'h0BB8);
  endtask
  task automatic t_internal;
    wr(8'h54, 32'h00000200);
    wr(8'h50, 32'h00000004);
    put(1'b0, 1'b0, 16'sh0000, 16'sh0000);
    `CHK(fwd, 16'h0200);
    wr(8'h56, 32'h00000000);
    put(1'b0, 1'b0, 16'sh0000, 16'sh0000);
    `CHK(fwd, 16'h0BB8);
  endtask
  task automatic t_clamp;
    wr(8'h50, 32'h00000001);
    wr(8'h51, 32'h00001388);
    put(1'b0, 1'b0, 16'sh0000, 16'sh0000);
    `CHK(fwd, 16'h0BB8);
  endtask
  task automatic t_uv;
    wr(8'h47, 32'h00000004);
    wr(8'h59, 32'h00000002);
    wr(8'h45, 32'h00000001);
    put(1'b0, 1'b1, 16'sh0000, 16'sh0000);
    `CHK(uvo, 1'b1);
    `CHK(fwd, 16'h0BB8);
    `CHK(irq, 1'b1);
    wr(8'h58, 32'h00000002);
    `CHK(irq, 1'b0);
    put(1'b0, 1'b0, 16'sh0000, 16'sh0000);
    wr(8'h45, 32'h00000003);
    rd(8'h45);
    `CHK(v, 32'h00000001);
    wr(8'h59, 32'h00000000);
    wr(8'h45, 32'h00000002);
    put(1'b0, 1'b1, 16'sh0000, 16'sh0000);
    `CHK(fwd, 16'h05DC);
    `CHK(irq, 1'b0);
    mot.drive(1'b0, 1'b0, 16'sh0000, 16'sh0000);
    repeat (25) @(posedge clk);
    `CHK((fwd > 16'h05DC) && (fwd < 16'h0BB8), 1'b1);
    repeat (40) @(posedge clk);
    `CHK(fwd, 16'h0BB8);
    wr(8'h45, 32'h00000000);
    put(1'b0, 1'b1, 16'sh0000, 16'sh0000);
    `CHK(uvo, 1'b0);
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_one();
    t_split();
    t_switch();
    t_analog();
    t_internal();
    t_clamp();
    t_uv();
    summarize();
  end
endmodule // servo_torque_limit_selector_test
`default_nettype wire
